//--- verification/tb_top.sv
/* self-checking bench: apb master, transmit and receive frames.
   assumes design header, package and checker compile first. */
`timescale 1ns/10ps
`include "udbbg_defines.svh"
module tb_top;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, rx_pin, tx_pin, irq;
  logic ext_clk, got_stb;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] b, got_byte;
  logic [15:0] got_cyc;
  logic [1:0] ec;
  logic [32:0] apb_q[$];
  logic [23:0] tx_q[$];
  int error_cnt = 0;
  int n_compared = 0;
  int seed = 71;
  int cyc = 0;
  int bt;
  // ----
  // setups: control, reload, timer clock period in cycles
  // ----
  logic [3:0] ctl [5] = '{4'h6, 4'h0, 4'h1, 4'h2, 4'h3};
  logic [7:0] rld [5] = '{8'hfe, 8'hfe, 8'hfd, 8'hff, 8'hff};
  int dv [5] = '{1, 12, 4, 48, 48};

  udbbg_top u_udbbg_top (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_pin(rx_pin), .external_osc_clock(ext_clk), .tx_pin(tx_pin),
    .irq(irq));
  udbbg_remote_uart u_udbbg_remote_uart (.clk_sys(clk_sys), .tx_pin(tx_pin),
    .rx_pin(rx_pin), .got_stb(got_stb), .got_byte(got_byte), .got_cyc(got_cyc));

  // 10 mhz system clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // external oscillator of six cycles, slow enough for its synchroniser
  initial {ec, ext_clk} = '0;
  always @(posedge clk_sys) begin
    ec <= (ec == 2'd2) ? 2'd0 : ec + 2'd1;
    if (ec == 2'd2) ext_clk <= ~ext_clk;
  end
  // ----
  // checking
  // ----
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] s);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task test_done();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  // results are matched against the oldest note when they appear
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      test_done();
    end
    if (pready === 1'b1 && apb_q.size() > 0)
      chk("apb", {7'h0, apb_q.pop_front()}, {7'h0, pslverr, pwrite ? 32'h0 : prdata});
    if (got_stb === 1'b1 && tx_q.size() > 0)
      chk("tx", {16'h0, tx_q.pop_front()}, {16'h0, got_cyc, got_byte});
  end
  // one apb transfer, held until ready, then one idle edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] exp);
    apb_q.push_back(exp);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  // ----
  // main sequence
  // ----
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst = 1'b1;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    apb(1'b0, `UDBBG_ADDR_DATA, 32'h0, 33'h0);
    apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
    apb(1'b1, `UDBBG_ADDR_MASK, 32'h0, 33'h0);
    for (int i = 0; i < 5; i++) begin
      b = 8'($random(seed)) & 8'hfc | 8'h01;
      bt = 32 * (256 - rld[i]) * dv[i];
      apb(1'b1, `UDBBG_ADDR_CTRL, {28'h0, ctl[i]}, 33'h0);
      apb(1'b1, `UDBBG_ADDR_RELOAD, {24'h0, rld[i]}, 33'h0);
      tx_q.push_back({16'(bt), b});
      apb(1'b1, `UDBBG_ADDR_DATA, {24'h0, b}, 33'h0);
      while (tx_q.size() > 0) @(posedge clk_sys);
      repeat (2 * bt) @(posedge clk_sys);
      apb(1'b0, `UDBBG_ADDR_STAT, 32'h0, 33'h2);
      apb(1'b0, `UDBBG_ADDR_STAT, 32'h0, 33'h0);
      apb(1'b0, `UDBBG_ADDR_DATA, 32'h0, 33'h0);
    end
    apb(1'b1, `UDBBG_ADDR_CTRL, 32'hc, 33'h0);
    apb(1'b1, `UDBBG_ADDR_RELOAD, 32'hff, 33'h0);
    apb(1'b1, `UDBBG_ADDR_MASK, 32'h1, 33'h0);
    b = 8'($random(seed));
    u_udbbg_remote_uart.send(b, 32);
    repeat (4) @(posedge clk_sys);
    chk("irq", 40'h1, {39'h0, irq});
    apb(1'b0, `UDBBG_ADDR_DATA, 32'h0, {25'h0, b});
    apb(1'b0, `UDBBG_ADDR_STAT, 32'h0, 33'h1);
    @(posedge clk_sys);
    chk("irq", 40'h0, {39'h0, irq});
    test_done();
  end
endmodule : tb_top

//--- verification/udbbg_assertions.sv
/* checker of the apb answer and serial start of the data buffer block.
   assumes a bind onto udbbg_top and a single clock domain. */
`timescale 1ns/10ps
`include "udbbg_defines.svh"
module udbbg_assertions (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // serial and interrupt
  input wire logic tx_pin,
  input wire logic irq
);
  // ----
  // decode
  // ----
  logic mapped;
  logic tx_load;
  // an accepted data write is the frame trigger
  assign mapped = paddr inside {`UDBBG_ADDR_DATA, `UDBBG_ADDR_CTRL, `UDBBG_ADDR_STAT,
    `UDBBG_ADDR_MASK, `UDBBG_ADDR_RELOAD};
  assign tx_load = psel && penable && pready && pwrite && paddr == `UDBBG_ADDR_DATA;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----
  // properties
  // ----
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_unmapped_error: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_no_error: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  a_read_byte_only: assert property (pready && !pwrite && paddr == `UDBBG_ADDR_DATA
    |-> prdata[31:8] == 24'h0)
    else $error("data read wider than a byte");
  a_tx_start_now: assert property (tx_load |=> !tx_pin)
    else $error("frame did not start");
  a_start_bit_held: assert property (tx_load |=> (!tx_pin)[*8])
    else $error("start bit too short");
  a_reset_idle: assert property ($fell(rst) |-> tx_pin && !irq && !pready)
    else $error("outputs not idle after reset");
  // main scenarios
  c_tx_load: cover property (tx_load);
  c_rx_irq: cover property ($rose(irq));
  c_refused: cover property (pready && pslverr);
endmodule : udbbg_assertions

bind udbbg_top udbbg_assertions u_udbbg_assertions (.clk_sys(clk_sys), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tx_pin(tx_pin), .irq(irq));

//--- verification/udbbg_remote_uart.sv
/* remote serial device: sends frames on rx_pin, decodes frames on tx_pin.
   assumes 8n1 frames whose first data bit is 1, used to time a bit. */
`timescale 1ns/10ps
module udbbg_remote_uart (
  // clock
  input wire logic clk_sys,
  // serial lines
  input wire logic tx_pin,
  output logic rx_pin,
  // decoded frame, one clock strobe
  output logic got_stb,
  output logic [7:0] got_byte,
  output logic [15:0] got_cyc
);
  int n;
  // line idles at mark level
  initial begin
    rx_pin = 1'b1;
    got_stb = 1'b0;
  end
  // one frame lsb first, each bit changed right after an edge
  task automatic send(input logic [7:0] b, input int bit_cyc);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_pin <= f[i];
      repeat (bit_cyc) @(posedge clk_sys);
    end
  endtask : send
  // bit time measured on data bit 0, so no rate is assumed here
  always begin
    @(negedge tx_pin);
    @(posedge tx_pin);
    n = 0;
    got_byte[0] = 1'b1;
    while (tx_pin === 1'b1) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    repeat (n / 2) @(posedge clk_sys);
    for (int i = 1; i < 8; i++) begin
      got_byte[i] = tx_pin;
      if (i < 7) repeat (n) @(posedge clk_sys);
    end
    got_cyc = 16'(n);
    #1;
    got_stb = 1'b1;
    @(posedge clk_sys);
    #1;
    got_stb = 1'b0;
  end
endmodule : udbbg_remote_uart

//--- verilog/udbbg_baud.sv
/*
  baud tick generator: prescaler then 8-bit reload timer.
  assumes ext_clk_sync is already synchronised to clk_sys.
*/
`timescale 1ns/10ps
`include "udbbg_defines.svh"

module udbbg_baud
  import udbbg_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // configuration
  input wire logic [1:0] timer_prescale_select,
  input wire logic timer1_core_clock_select,
  input wire logic [7:0] reload,
  input wire logic ext_clk_sync,
  // ticks at sixteen times the bit rate
  output logic os_tick
);

  logic [5:0] pre_cnt_q;
  logic [5:0] pre_lim;
  logic ext_q;
  logic ext8_tick;
  logic pre_tick;
  logic [7:0] tmr_q;
  logic half_q;
  logic [5:0] ext_cnt_q;

  // prescale limit from the select code
  always_comb begin
    case (udbbg_presc_t'(timer_prescale_select))
      UDBBG_PS_DIV12: pre_lim = `UDBBG_DIV12_M1;
      UDBBG_PS_DIV4: pre_lim = `UDBBG_DIV4_M1;
      UDBBG_PS_DIV48: pre_lim = `UDBBG_DIV48_M1;
      default: pre_lim = `UDBBG_DIV4_M1;
    endcase
  end

  // system clock prescaler
  always_ff @(posedge clk_sys) begin
    if (rst || pre_cnt_q >= pre_lim) begin
      pre_cnt_q <= 6'h00;
    end else begin
      pre_cnt_q <= pre_cnt_q + 6'h01;
    end
  end

  // external clock divide by eight, counted on rising edges
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ext_q <= 1'b0;
      ext_cnt_q <= 6'h00;
    end else begin
      ext_q <= ext_clk_sync;
      if (ext_clk_sync && !ext_q) begin
        ext_cnt_q <= (ext_cnt_q >= `UDBBG_EXT8_M1) ? 6'h00 : ext_cnt_q + 6'h01;
      end
    end
  end
  assign ext8_tick = ext_clk_sync && !ext_q && (ext_cnt_q == `UDBBG_EXT8_M1);

  // core clock select bypasses the prescaler entirely
  assign pre_tick = timer1_core_clock_select ? 1'b1 :
    (timer_prescale_select == UDBBG_PS_EXT8) ? ext8_tick :
    (pre_cnt_q == pre_lim);

  // reload timer; overflow every (256 - reload) inputs, halved to a tick
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tmr_q <= `UDBBG_RST_RELOAD;
      half_q <= 1'b0;
      os_tick <= 1'b0;
    end else begin
      os_tick <= 1'b0;
      if (pre_tick) begin
        if (tmr_q == 8'hff) begin
          tmr_q <= reload;
          half_q <= !half_q;
          os_tick <= half_q;
        end else begin
          tmr_q <= tmr_q + 8'h01;
        end
      end
    end
  end

endmodule : udbbg_baud

//--- verilog/udbbg_defines.svh
/*
  constant header for the uart data buffer and baud generator.
  assumes it is included by bare name from design and bench files.
*/
`ifndef UDBBG_DEFINES_SVH
`define UDBBG_DEFINES_SVH

// ------------------------------------------------------------
// register byte addresses (printed offset 0x99 is not word aligned)
// ------------------------------------------------------------
`define UDBBG_IDX_DATA 8'h99
`define UDBBG_ADDR_DATA 12'h264
`define UDBBG_ADDR_CTRL 12'h000
`define UDBBG_ADDR_STAT 12'h004
`define UDBBG_ADDR_MASK 12'h008
`define UDBBG_ADDR_RELOAD 12'h00c

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define UDBBG_CTRL_PRESC_LSB 0
`define UDBBG_CTRL_CORESEL 2
`define UDBBG_CTRL_RXEN 3
`define UDBBG_STAT_RXDONE 0
`define UDBBG_STAT_TXDONE 1
`define UDBBG_STAT_TXBUSY 2
`define UDBBG_RST_DATA 8'h00
`define UDBBG_RST_CTRL 4'h0
`define UDBBG_RST_RELOAD 8'h00

// ------------------------------------------------------------
// prescale divide counts (minus one) and the oversample count
// ------------------------------------------------------------
`define UDBBG_DIV12_M1 6'h0b
`define UDBBG_DIV4_M1 6'h03
`define UDBBG_DIV48_M1 6'h2f
`define UDBBG_EXT8_M1 6'h07
`define UDBBG_SAMPLES 5'h10

`endif

//--- verilog/udbbg_pkg.sv
/*
  types shared by the uart data buffer design.
  assumes nothing beyond a systemverilog compiler.
*/
package udbbg_pkg;

  // prescale codes of the baud timer input
  typedef enum logic [1:0] {
    UDBBG_PS_DIV12 = 2'b00,
    UDBBG_PS_DIV4 = 2'b01,
    UDBBG_PS_DIV48 = 2'b10,
    UDBBG_PS_EXT8 = 2'b11
  } udbbg_presc_t;

  // transmit and receive sequencer states
  typedef enum logic [1:0] {
    UDBBG_IDLE = 2'b00,
    UDBBG_START = 2'b01,
    UDBBG_DATA = 2'b10,
    UDBBG_STOP = 2'b11
  } udbbg_state_t;

endpackage : udbbg_pkg

//--- verilog/udbbg_top.sv
/*
  uart data buffer, baud timing and an apb register slave.
  assumes apb master on clk_sys; rx pin and external clock asynchronous.
*/
`timescale 1ns/10ps
`include "udbbg_defines.svh"

// How it works
// - one data buffer address writes the transmit shifter and reads the receive latch.
// - a written byte sits in the transmit shifter until shifted out or overwritten by the next write.
// - each write of the data buffer starts a frame at once.
// - a read of the data buffer gives the last received byte, never tx data.
// - with core select low the prescale code picks clk/12, clk/4, clk/48 or ext/8.
// - with core select high the timer runs on the system clock, code ignored.
// - receive and transmit done flags are set by hardware and cleared by software.
module udbbg_top
  import udbbg_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link and external oscillator
  input wire logic rx_pin,
  input wire logic external_osc_clock,
  output logic tx_pin,
  // interrupt
  output logic irq
);

  // ------------------------------------------------------------
  // registers and synchronisers
  // ------------------------------------------------------------
  logic [3:0] ctrl_q;
  logic [7:0] reload_q;
  logic [1:0] stat_q;
  logic [1:0] mask_q;
  logic [7:0] rx_latch_q;
  logic rx_s1_q, rx_s2_q, ext_s1_q, ext_s2_q;
  logic os_tick;
  logic wr_en, rd_en;
  logic tx_set, rx_set;
  // transmitter state, declared here because the read mux shows the busy bit
  udbbg_state_t tx_st_q;
  logic [7:0] tx_sh_q;
  logic [3:0] tx_os_q;
  logic [2:0] tx_bit_q;
  logic tx_busy;
  assign tx_busy = (tx_st_q != UDBBG_IDLE);

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a == r);
  endfunction : hit

  // pins cross two flops before use
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
    end else begin
      rx_s1_q <= rx_pin;
      rx_s2_q <= rx_s1_q;
      ext_s1_q <= external_osc_clock;
      ext_s2_q <= ext_s1_q;
    end
  end

  udbbg_baud u_baud (
    .clk_sys(clk_sys),
    .rst(rst),
    .timer_prescale_select(ctrl_q[`UDBBG_CTRL_PRESC_LSB +: 2]),
    .timer1_core_clock_select(ctrl_q[`UDBBG_CTRL_CORESEL]),
    .reload(reload_q),
    .ext_clk_sync(ext_s2_q),
    .os_tick(os_tick)
  );

  // ------------------------------------------------------------
  // apb slave: zero wait, answer in the access cycle
  // ------------------------------------------------------------
  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && penable && !pwrite && pready;

  // pready pulses for the access cycle only, registered
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  // read mux registered in the setup cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      if (hit(paddr, `UDBBG_ADDR_DATA)) begin
        prdata <= {24'h000000, rx_latch_q};
      end else if (hit(paddr, `UDBBG_ADDR_CTRL)) begin
        prdata <= {28'h0000000, ctrl_q};
      end else if (hit(paddr, `UDBBG_ADDR_STAT)) begin
        prdata <= {29'h00000000, tx_busy, stat_q};
      end else if (hit(paddr, `UDBBG_ADDR_MASK)) begin
        prdata <= {30'h00000000, mask_q};
      end else if (hit(paddr, `UDBBG_ADDR_RELOAD)) begin
        prdata <= {24'h000000, reload_q};
      end else begin
        pslverr <= 1'b1; // unmapped address
      end
    end
  end

  // software configuration
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= `UDBBG_RST_CTRL;
      reload_q <= `UDBBG_RST_RELOAD;
      mask_q <= 2'b00;
    end else if (wr_en) begin
      if (hit(paddr, `UDBBG_ADDR_CTRL)) ctrl_q <= pwdata[3:0];
      if (hit(paddr, `UDBBG_ADDR_RELOAD)) reload_q <= pwdata[7:0];
      if (hit(paddr, `UDBBG_ADDR_MASK)) mask_q <= pwdata[1:0];
    end
  end

  // sticky done flags, read of status clears, a new set wins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stat_q <= 2'b00;
    end else begin
      if (rd_en && hit(paddr, `UDBBG_ADDR_STAT)) stat_q <= 2'b00;
      if (rx_set) stat_q[`UDBBG_STAT_RXDONE] <= 1'b1;
      if (tx_set) stat_q[`UDBBG_STAT_TXDONE] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) irq <= 1'b0;
    else irq <= |((stat_q | {tx_set, rx_set}) & mask_q);
  end

  // ------------------------------------------------------------
  // transmitter: 8n1, lsb first
  // ------------------------------------------------------------
  // a write restarts the frame even mid-transfer: the byte in flight is dropped without a flag
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_st_q <= UDBBG_IDLE;
      tx_sh_q <= `UDBBG_RST_DATA;
      tx_os_q <= 4'h0;
      tx_bit_q <= 3'h0;
      tx_pin <= 1'b1;
      tx_set <= 1'b0;
    end else begin
      tx_set <= 1'b0;
      if (wr_en && hit(paddr, `UDBBG_ADDR_DATA)) begin
        tx_sh_q <= pwdata[7:0];
        tx_st_q <= UDBBG_START;
        tx_os_q <= 4'h0;
        tx_pin <= 1'b0;
      end else if (os_tick && tx_busy) begin
        tx_os_q <= tx_os_q + 4'h1;
        if (tx_os_q == 4'hf) begin
          case (tx_st_q)
            UDBBG_START: begin
              tx_st_q <= UDBBG_DATA;
              tx_bit_q <= 3'h0;
              tx_pin <= tx_sh_q[0];
            end
            UDBBG_DATA: begin
              tx_sh_q <= {1'b0, tx_sh_q[7:1]};
              tx_bit_q <= tx_bit_q + 3'h1;
              if (tx_bit_q == 3'h7) begin
                tx_st_q <= UDBBG_STOP;
                tx_pin <= 1'b1;
                tx_set <= 1'b1;
              end else begin
                tx_pin <= tx_sh_q[1];
              end
            end
            default: tx_st_q <= UDBBG_IDLE;
          endcase
        end
      end
    end
  end

  // ------------------------------------------------------------
  // receiver: samples mid-bit on the oversample ticks
  // ------------------------------------------------------------
  udbbg_state_t rx_st_q;
  logic [7:0] rx_sh_q;
  logic [3:0] rx_os_q;
  logic [2:0] rx_bit_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_st_q <= UDBBG_IDLE;
      rx_sh_q <= 8'h00;
      rx_os_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_latch_q <= `UDBBG_RST_DATA;
      rx_set <= 1'b0;
    end else begin
      rx_set <= 1'b0;
      if (os_tick) begin
        rx_os_q <= rx_os_q + 4'h1;
        case (rx_st_q)
          UDBBG_IDLE: begin
            rx_os_q <= 4'h0;
            if (!rx_s2_q && ctrl_q[`UDBBG_CTRL_RXEN]) rx_st_q <= UDBBG_START;
          end
          UDBBG_START: if (rx_os_q == 4'h7) begin
            rx_os_q <= 4'h0;
            rx_bit_q <= 3'h0;
            rx_st_q <= rx_s2_q ? UDBBG_IDLE : UDBBG_DATA; // glitch rejected
          end
          UDBBG_DATA: if (rx_os_q == 4'hf) begin
            rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == 3'h7) rx_st_q <= UDBBG_STOP;
          end
          UDBBG_STOP: if (rx_os_q == 4'hf) begin
            rx_st_q <= UDBBG_IDLE;
            rx_latch_q <= rx_sh_q;
            rx_set <= 1'b1;
          end
          default: rx_st_q <= UDBBG_IDLE;
        endcase
      end
    end
  end

endmodule : udbbg_top
